// ===== dv/pio_pads_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// External circuitry on the pads
// ----------------------------------------------------------------
// Resolves each pad from the cell drive, the pull-up and what the
// board drives. A pad nobody holds toggles every cycle, so a design
// that reads a floating pad cannot pass by luck.
module pio_pads_model (
	input  wire logic                     pclk,
	input  pio_pkg::pio_pad_s             pad,
	input  wire logic [pio_pkg::NPIN-1:0] ext_en,
	input  wire logic [pio_pkg::NPIN-1:0] ext_val,
	output logic      [pio_pkg::NPIN-1:0] pad_i
);
	import pio_pkg::*;

	logic flt = 1'b0; // Level shown by an undriven, unpulled pad.

	// The floating level changes on every clock.
	always_ff @(posedge pclk) begin
		flt <= ~flt;
	end

	// The cell driver wins, then the board, then the pull-up.
	always_comb begin
		for (int i = 0; i < NPIN; i++) begin
			if (pad.oe[i]) begin
				pad_i[i] = pad.o[i];
			end else if (ext_en[i]) begin
				pad_i[i] = ext_val[i];
			end else if (pad.pu[i]) begin
				pad_i[i] = 1'b1;
			end else begin
				pad_i[i] = flt;
			end
		end
	end
endmodule

// ===== dv/pio_port_bench.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port block bench
// ----------------------------------------------------------------
`define CHK(n, x, g) begin compares++; if ((g) !== (x)) begin \
	bad_count++; $display("MISMATCH %s exp %h got %h", n, x, g); end end
module pio_port_bench;
	import pio_pkg::*;

	logic                  pclk;      // Bus clock, 40 MHz.
	logic                  presetn;   // Reset, active low.
	logic                  ce;        // Clock enable.
	logic                  psel;      // APB select.
	logic                  penable;   // APB access phase.
	logic                  pwrite;    // APB direction.
	logic [11:0]           paddr;     // APB address.
	logic [31:0]           pwdata;    // APB write data.
	logic [31:0]           prdata;    // APB read data.
	logic                  pready;    // APB answer.
	logic                  pslverr;   // APB error.
	logic [NPIN-1:0]       pad_i;     // Resolved pad levels.
	pio_pad_s              pad;       // Cell drive.
	logic                  vref_en;   // Reference owns pin 0.
	logic                  xosc_en;   // Oscillator owns pins 2 and 3.
	logic [NSIG-1:0]       periph_o;  // Peripheral output values.
	logic [NSIG-1:0]       periph_oe; // Peripheral drive requests.
	logic [NSIG-1:0]       periph_i;  // Levels seen by peripherals.
	logic                  ext_event; // Event pulse.
	logic [NPIN-1:0]       ext_en;    // Board drives the pad.
	logic [NPIN-1:0]       ext_val;   // Board drive level.
	int                    bad_count; // Mismatches seen.
	int                    compares;  // Comparisons made.
	int                    c;         // Event pulses counted.

	// The tests drop the clock enable once to see that state freezes.
	pio_port pio_port_inst (.pclk(pclk), .presetn(presetn), .ce(ce),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pad_i(pad_i), .pad(pad), .vref_en(vref_en),
		.xosc_en(xosc_en), .periph_o(periph_o), .periph_oe(periph_oe),
		.periph_i(periph_i), .ext_event(ext_event));
	pio_pads_model pio_pads_model_inst (.pclk(pclk), .pad(pad),
		.ext_en(ext_en), .ext_val(ext_val), .pad_i(pad_i));

	// ----------------------------------------------------------------
	// Clock and verdict
	// ----------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	// Prints the verdict and stops the run.
	task automatic conclude;
		if (bad_count == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// The tests take well under a thousand cycles.
	initial begin
		repeat (5000) @(posedge pclk);
		bad_count++;
		conclude();
	end

	// ----------------------------------------------------------------
	// Access tasks
	// ----------------------------------------------------------------
	// One APB transfer; the request holds until pready is sampled high.
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait that never sees pready.
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// Writes one register word.
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, {24'h0, d}, q, e);
	endtask

	// Reads one register and compares the word and the error flag.
	task automatic rd(input logic [11:0] a, input logic [31:0] x,
		input logic xe);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0, q, e);
		`CHK("rdata", x, q)
		`CHK("slverr", xe, e)
	endtask

	// Byte address of a register in port block n.
	function automatic logic [11:0] pa(input int n, input logic [3:0] o);
		return A_PBASE + 12'(n) * A_PSTEP + {8'h00, o};
	endfunction

	// Lets pad drive and the input synchroniser settle.
	task automatic settle;
		repeat (4) @(posedge pclk);
	endtask

	// Counts event pulses over a short bounded span.
	task automatic ev_cnt(output int n);
		n = 0;
		repeat (8) begin
			@(posedge pclk);
			if (ext_event === 1'b1) n++;
		end
	endtask

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		bad_count = 0;
		compares  = 0;
		presetn   = 1'b0;
		ce        = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{vref_en, xosc_en, periph_o, periph_oe} = '0;
		ext_en  = '0;
		ext_val = '0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		`CHK("oe_rst", {NPIN{1'b0}}, pad.oe)
		`CHK("pu_rst", {NPIN{1'b1}}, pad.pu)
		rd(A_CTRL, 32'h0, 1'b0);
		rd(pa(0, O_MDIN), 32'hff, 1'b0);
		rd(pa(0, O_LAT), 32'hff, 1'b0);
		rd(12'h800, 32'h0, 1'b1);
		// Global pull-up disable, then back on.
		wr(A_CTRL, 8'h02);
		settle();
		`CHK("pu_off", {NPIN{1'b0}}, pad.pu)
		wr(A_CTRL, 8'h00);
		// Analog upper half of port 2 while the board drives it high.
		ext_en[23:16]  <= 8'hff;
		ext_val[23:16] <= 8'hff;
		wr(pa(2, O_MDIN), 8'h0f);
		settle();
		`CHK("pu_an", 4'h0, pad.pu[23:20])
		`CHK("oe_an", 8'h00, pad.oe[23:16])
		rd(pa(2, O_LAT), 32'h0f, 1'b0);
		wr(pa(4, O_MDIN), 8'h00);
		rd(pa(4, O_MDIN), 32'hff, 1'b0);
		`CHK("pu_p4", 8'hff, pad.pu[39:32])
		// Fixed analog functions take their own pins; no pin left
		// digital is ever borrowed as an analog input.
		vref_en <= 1'b1;
		xosc_en <= 1'b1;
		settle();
		`CHK("pu_fix", 4'b0010, pad.pu[3:0])
		rd(pa(0, O_LAT), 32'hf2, 1'b0);
		vref_en <= 1'b0;
		xosc_en <= 1'b0;
		// Crossbar on; port 3 reserved as GPIO.
		wr(A_CTRL, 8'h01);
		wr(pa(3, O_SKIP), 8'hff);
		wr(pa(3, O_MDOUT), 8'hff);
		wr(pa(3, O_LAT), 8'ha5);
		settle();
		`CHK("pp_o", 8'ha5, pad.o[31:24])
		`CHK("pp_oe", 8'hff, pad.oe[31:24])
		wr(pa(3, O_MDOUT), 8'h00);
		settle();
		`CHK("od_oe", 8'h5a, pad.oe[31:24] | pad.o[31:24])
		`CHK("od_pu", 8'ha5, pad.pu[31:24])
		rd(pa(3, O_LAT), 32'ha5, 1'b0);
		ext_en[24]  <= 1'b1;
		ext_val[24] <= 1'b0;
		settle();
		rd(pa(3, O_LAT), 32'ha4, 1'b0);
		// Fixed serial pair ignores its reserve bits; the CAN pair sits on unreserved pins.
		wr(pa(0, O_SKIP), 8'h3f);
		wr(pa(0, O_MDOUT), 8'h50);
		periph_oe[2] <= 1'b1;
		periph_o[2]  <= 1'b1;
		periph_oe[0] <= 1'b1;
		ext_en[7]    <= 1'b1;
		ext_en[5]    <= 1'b1;
		wr(A_SEL0, 8'h01);
		wr(A_SEL2, 8'h01);
		settle();
		`CHK("fix_oe", 2'b11, {pad.oe[6], pad.oe[4]})
		`CHK("fix_o", 2'b10, {pad.o[6], pad.o[4]})
		`CHK("fix_in", 2'b00, {periph_i[3], periph_i[1]})
		// Comparator 0 takes the lowest free pin past the reserved ones.
		periph_oe[10] <= 1'b1;
		periph_o[10]  <= 1'b1;
		wr(pa(1, O_MDOUT), 8'h01);
		wr(A_SEL1, 8'h01);
		settle();
		`CHK("cmp_p8", 3'b110, {pad.oe[8], pad.o[8], pad.oe[0]})
		wr(pa(0, O_MDOUT), 8'h51);
		wr(pa(0, O_SKIP), 8'h3e);
		periph_o[10] <= 1'b0;
		settle();
		`CHK("cmp_p0", 3'b110, {pad.o[8], pad.oe[0], pad.o[0]})
		// A low clock enable freezes the cells; the reference function
		// only reaches pin 0 once the clock runs again.
		ce      <= 1'b0;
		vref_en <= 1'b1;
		settle();
		`CHK("ce_hold", 1'b1, pad.oe[0])
		ce <= 1'b1;
		settle();
		`CHK("ce_run", 1'b0, pad.oe[0])
		vref_en <= 1'b0;
		// Events on port 1 pin 3, reserved but digital.
		ext_en[11]  <= 1'b1;
		wr(pa(1, O_SKIP), 8'h08);
		wr(A_EVCFG, 8'h1b);
		settle();
		ext_val[11] <= 1'b1;
		ev_cnt(c);
		`CHK("ev_rise", 1, c)
		ext_val[11] <= 1'b0;
		ev_cnt(c);
		`CHK("ev_fall", 0, c)
		// Same pin with the falling-edge polarity.
		wr(A_EVCFG, 8'h13);
		ext_val[11] <= 1'b1;
		ev_cnt(c);
		`CHK("evf_rise", 0, c)
		ext_val[11] <= 1'b0;
		ev_cnt(c);
		`CHK("evf_fall", 1, c)
		wr(A_EVCFG, 8'h1b);
		wr(pa(1, O_MDIN), 8'hf7);
		settle();
		ext_val[11] <= 1'b1;
		ev_cnt(c);
		`CHK("ev_an", 0, c)
		// Reset in mid-run: cells fall back to high impedance and stay
		// there until the crossbar is enabled again.
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		`CHK("oe_rst2", {NPIN{1'b0}}, pad.oe)
		presetn <= 1'b1;
		settle();
		`CHK("oe_idle", {NPIN{1'b0}}, pad.oe)
		rd(A_CTRL, 32'h0, 1'b0);
		conclude();
	end
endmodule

// ===== src/pio_pkg.sv
// Summary of operation
// - Port reads show pin state, any crossbar setting.
// - Three select registers choose crossbar peripheral functions.
// - Reset: cells high impedance, pull-ups on, until enabled.
// - Analog pin: pull-up, driver and receiver off.
// - Analog pin always reads back zero.
// - Digital pin serves peripherals, events or GPIO.
// - Push-pull drives pad high or low.
// - Open-drain drives low only, else released.
// - Released digital pin pulled up, not while low.
// - Global disable bit turns off all pull-ups.
// - Digital read returns pad level, not latch.
// - Fifth port is digital only.
// - Reserved pins never claimed by the crossbar, except fixed serial and CAN pins.
// - Reference, crystal, oscillator pins fixed on port zero.
// - Serial port fixed bits 4-5, CAN bits 6-7.
// - Selected event pin transition raises an event.
// - Events work skipped or not, never analog.
// - Each non-fixed resource takes lowest free unreserved pin.
package pio_pkg;
	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int NPORT = 5;            // Ports in the device.
	localparam int PW    = 8;            // Pins per port.
	localparam int NPIN  = NPORT * PW;   // All pins.
	localparam int NSIG  = 12;           // Crossbar peripheral signals.
	localparam int DIGONLY_PORT = 4;     // Port with no analog function.
	// ----------------------------------------------------------------
	// Register byte addresses
	// ----------------------------------------------------------------
	localparam logic [11:0] A_CTRL  = 12'h000; // Enable and pull-up bits.
	localparam logic [11:0] A_SEL0  = 12'h004; // function_select_first.
	localparam logic [11:0] A_SEL1  = 12'h008; // function_select_second.
	localparam logic [11:0] A_SEL2  = 12'h00c; // function_select_third.
	localparam logic [11:0] A_EVCFG = 12'h010; // ext_int_pin_config.
	localparam logic [11:0] A_PBASE = 12'h020; // First port block.
	localparam logic [11:0] A_PSTEP = 12'h010; // Stride between ports.
	localparam logic [3:0]  O_LAT   = 4'h0;    // Latch write, pad read.
	localparam logic [3:0]  O_MDIN  = 4'h4;    // pin_input_kind_select.
	localparam logic [3:0]  O_MDOUT = 4'h8;    // pin_output_type_select.
	localparam logic [3:0]  O_SKIP  = 4'hc;    // crossbar_pin_reserve_mask.
	// ----------------------------------------------------------------
	// Fields and reset values
	// ----------------------------------------------------------------
	localparam int B_XBAR_EN = 0;        // crossbar_enable_bit.
	localparam int B_WPUD  = 1;          // global_pullup_disable.
	localparam int B_EVPOL = 3;          // Event on rising edge when 1.
	localparam int B_EVEN  = 4;          // Event capture enable.
	localparam logic [7:0] RST_LAT   = 8'hff;
	localparam logic [7:0] RST_MDIN  = 8'hff;
	localparam logic [7:0] RST_MDOUT = 8'h00;
	localparam logic [7:0] RST_SKIP  = 8'h00;
	// ----------------------------------------------------------------
	// Fixed pin positions (flat pin index = port * 8 + bit)
	// ----------------------------------------------------------------
	localparam int PIN_VREF  = 0;        // Reference input.
	localparam int PIN_XTAL1 = 2;        // Crystal input.
	localparam int PIN_XTAL2 = 3;        // Second oscillator pin.
	localparam int PIN_UART  = 4;        // Serial port pair start.
	localparam int PIN_CAN   = 6;        // CAN pair start.
	localparam int EV_PORT   = 1;        // Port that holds event pins.
	localparam int FIRST_GEN = 4;        // First priority-routed signal.

	// Pad drive of all pins, registered as a group.
	typedef struct packed {
		logic [NPIN-1:0] o;              // Output level.
		logic [NPIN-1:0] oe;             // Driver on.
		logic [NPIN-1:0] pu;             // Weak pull-up on.
	} pio_pad_s;
endpackage

// ===== src/pio_port.sv
`timescale 1ns/1ps
module pio_port (
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	input  wire logic                      ce,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [11:0]               paddr,
	input  wire logic [31:0]               pwdata,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	input  wire logic [pio_pkg::NPIN-1:0]  pad_i,
	output pio_pkg::pio_pad_s              pad,
	input  wire logic                      vref_en,
	input  wire logic                      xosc_en,
	input  wire logic [pio_pkg::NSIG-1:0]  periph_o,
	input  wire logic [pio_pkg::NSIG-1:0]  periph_oe,
	output logic      [pio_pkg::NSIG-1:0]  periph_i,
	output logic                           ext_event
);
	import pio_pkg::*;

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	logic [NPIN-1:0] lat;        // Output latches.
	logic [NPIN-1:0] mdin;       // 1 = digital pin.
	logic [NPIN-1:0] mdout;      // 1 = push-pull.
	logic [NPIN-1:0] skip;       // 1 = reserved from the crossbar.
	logic [7:0]      ctrl;       // Enable and pull-up control.
	logic [7:0]      sel [3];    // Function selects.
	logic [7:0]      evcfg;      // Event pin, polarity, enable.
	logic [NPIN-1:0] pad_s1;     // First synchroniser stage.
	logic [NPIN-1:0] pad_s2;     // Synchronised pad levels.
	logic            ev_prev;    // Previous level of the event pin.

	// Effective digital mask: the fifth port cannot be analog and the
	// fixed analog pins go analog while their function is enabled.
	logic [NPIN-1:0] dig;
	logic [NSIG-1:0] sig_en;     // Peripheral signals switched on.
	logic [NPIN-1:0] owned;      // Pins claimed by the crossbar.
	logic [3:0]      owner [NPIN]; // Which signal owns each pin.
	logic [5:0]      sig_pin [NSIG]; // Pin given to each signal.
	logic [NSIG-1:0] sig_ok;     // Signal got a pin.
	pio_pad_s        next_pad;   // Cell drive before the register.
	logic [31:0]     next_rdata; // Read value for the setup address.
	logic            next_err;   // Address not mapped.

	always_comb begin
		dig = mdin;
		dig[DIGONLY_PORT*PW +: PW] = '1;
		if (vref_en) begin
			dig[PIN_VREF] = 1'b0;
		end
		if (xosc_en) begin
			dig[PIN_XTAL1] = 1'b0;
			dig[PIN_XTAL2] = 1'b0;
		end
	end

	// Serial pair, CAN pair, four-wire serial, two-wire serial, two
	// comparator outputs. Order of the vector is also the priority.
	always_comb begin
		sig_en = {sel[1][1], sel[1][0], {2{sel[0][2]}}, {4{sel[0][1]}},
			{2{sel[2][0]}}, {2{sel[0][0]}}};
	end

	// ----------------------------------------------------------------
	// Priority crossbar
	// ----------------------------------------------------------------
	// Returns the lowest pin index that is free, with a found flag in
	// the top bit.
	function automatic logic [6:0] lowest_free(input logic [NPIN-1:0] t);
		logic [6:0] r;
		r = '0;
		for (int i = NPIN - 1; i >= 0; i--) begin
			if (!t[i]) begin
				r = {1'b1, 6'(i)};
			end
		end
		return r;
	endfunction

	// Fixed pairs first, then each enabled signal in priority order
	// takes the lowest pin not reserved and not yet taken. A long chain
	// of priority encoders; timing grows with the number of signals.
	always_comb begin
		logic [NPIN-1:0] taken;
		logic [6:0]      f;
		taken = skip;
		taken[DIGONLY_PORT*PW +: PW] = skip[DIGONLY_PORT*PW +: PW];
		owned = '0;
		f = '0;
		sig_ok = '0;
		for (int p = 0; p < NPIN; p++) begin
			owner[p] = '0;
		end
		for (int k = 0; k < NSIG; k++) begin
			sig_pin[k] = '0;
		end
		for (int k = 0; k < FIRST_GEN; k++) begin
			if (sig_en[k]) begin
				sig_pin[k] = (k < 2) ? 6'(PIN_UART + k)
					: 6'(PIN_CAN + k - 2);
				sig_ok[k] = 1'b1;
			end
		end
		// Fixed pins are taken once their function is on.
		taken[PIN_UART +: 2] = taken[PIN_UART +: 2] | {2{sig_en[0]}};
		taken[PIN_CAN +: 2]  = taken[PIN_CAN +: 2] | {2{sig_en[2]}};
		for (int k = FIRST_GEN; k < NSIG; k++) begin
			if (sig_en[k]) begin
				f = lowest_free(taken);
				if (f[6]) begin
					sig_pin[k] = f[5:0];
					sig_ok[k] = 1'b1;
					taken[f[5:0]] = 1'b1;
				end
			end
		end
		for (int k = 0; k < NSIG; k++) begin
			if (sig_ok[k]) begin
				owned[sig_pin[k]] = 1'b1;
				owner[sig_pin[k]] = 4'(k);
			end
		end
	end

	// ----------------------------------------------------------------
	// Port cells
	// ----------------------------------------------------------------
	for (genvar p = 0; p < NPIN; p++) begin : g_cell
		logic src_o;   // Value from latch or peripheral.
		logic src_oe;  // Drive request from latch or peripheral.
		logic drv;     // Cell drives the pad.
		assign src_o  = owned[p] ? periph_o[owner[p]] : lat[p];
		assign src_oe = owned[p] ? periph_oe[owner[p]] : 1'b1;
		// Open drain only pulls low; push-pull follows the value.
		assign drv = ctrl[B_XBAR_EN] & dig[p] & src_oe
			& (mdout[p] | ~src_o);
		assign next_pad.oe[p] = drv;
		assign next_pad.o[p]  = mdout[p] & src_o;
		// Pull-up on while released or driving high, off when driving low.
		assign next_pad.pu[p] = dig[p] & ~ctrl[B_WPUD]
			& ~(drv & ~next_pad.o[p]);
	end

	// Cell drive register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pad.o  <= '0;
			pad.oe <= '0;
			pad.pu <= '1;
		end else if (ce) begin
			pad <= next_pad;
		end
	end

	// Pad synchroniser; only the second stage is used by logic.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pad_s1 <= '1;
			pad_s2 <= '1;
		end else if (ce) begin
			pad_s1 <= pad_i;
			pad_s2 <= pad_s1;
		end
	end

	// Inputs to peripherals; an analog or unassigned pin reads high.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			periph_i <= '1;
		end else if (ce) begin
			for (int k = 0; k < NSIG; k++) begin
				periph_i[k] <= sig_ok[k] ? (pad_s2[sig_pin[k]]
					| ~dig[sig_pin[k]]) : 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Event capture
	// ----------------------------------------------------------------
	logic ev_lvl; // Selected pin level, forced low when analog.
	logic ev_hit; // Transition to the chosen level.
	assign ev_lvl = pad_s2[EV_PORT*PW + int'(evcfg[2:0])]
		& dig[EV_PORT*PW + int'(evcfg[2:0])];
	assign ev_hit = evcfg[B_EVEN]
		& (evcfg[B_EVPOL] ? (ev_lvl & ~ev_prev) : (~ev_lvl & ev_prev));

	// One-cycle event pulse; works on reserved pins as well.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ev_prev   <= 1'b1; // Idle, pulled-up level.
			ext_event <= 1'b0;
		end else if (ce) begin
			ev_prev   <= ev_lvl;
			ext_event <= ev_hit;
		end
	end

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	// Read mux for the address in setup. A port read shows the pad,
	// and zero for an analog pin.
	always_comb begin
		next_rdata = '0;
		next_err   = 1'b0;
		if (paddr == A_CTRL) begin
			next_rdata[7:0] = ctrl;
		end else if (paddr == A_SEL0) begin
			next_rdata[7:0] = sel[0];
		end else if (paddr == A_SEL1) begin
			next_rdata[7:0] = sel[1];
		end else if (paddr == A_SEL2) begin
			next_rdata[7:0] = sel[2];
		end else if (paddr == A_EVCFG) begin
			next_rdata[7:0] = evcfg;
		end else begin
			next_err = 1'b1;
			for (int n = 0; n < NPORT; n++) begin
				if (paddr[11:4] == 8'((A_PBASE + n * A_PSTEP) >> 4)) begin
					next_err = 1'b0;
					if (paddr[3:0] == O_LAT) begin
						next_rdata[7:0] = pad_s2[n*PW +: PW]
							& dig[n*PW +: PW];
					end else if (paddr[3:0] == O_MDIN) begin
						next_rdata[7:0] = dig[n*PW +: PW];
					end else if (paddr[3:0] == O_MDOUT) begin
						next_rdata[7:0] = mdout[n*PW +: PW];
					end else if (paddr[3:0] == O_SKIP) begin
						next_rdata[7:0] = (n == DIGONLY_PORT) ? 8'h00
							: skip[n*PW +: PW];
					end else begin
						next_err = 1'b1;
					end
				end
			end
		end
	end

	// Zero-wait answer: ready and data are set from the setup phase.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= '0;
			pslverr <= 1'b0;
		end else if (ce) begin
			pready  <= psel & ~penable & ~pready;
			prdata  <= next_rdata;
			pslverr <= next_err & psel & ~penable;
		end
	end

	logic wr; // Write takes effect at the completing edge.
	assign wr = psel & penable & pready & pwrite & ~pslverr;

	// Global and event registers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl   <= '0;
			sel[0] <= '0;
			sel[1] <= '0;
			sel[2] <= '0;
			evcfg  <= '0;
		end else if (ce && wr) begin
			if (paddr == A_CTRL) begin
				ctrl <= pwdata[7:0];
			end else if (paddr == A_SEL0) begin
				sel[0] <= pwdata[7:0];
			end else if (paddr == A_SEL1) begin
				sel[1] <= pwdata[7:0];
			end else if (paddr == A_SEL2) begin
				sel[2] <= pwdata[7:0];
			end else if (paddr == A_EVCFG) begin
				evcfg <= pwdata[7:0];
			end
		end
	end

	// Per-port eight-bit registers, bit n for pin n.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lat   <= {NPORT{RST_LAT}};
			mdin  <= {NPORT{RST_MDIN}};
			mdout <= {NPORT{RST_MDOUT}};
			skip  <= {NPORT{RST_SKIP}};
		end else if (ce && wr) begin
			for (int n = 0; n < NPORT; n++) begin
				if (paddr[11:4] == 8'((A_PBASE + n * A_PSTEP) >> 4)) begin
					if (paddr[3:0] == O_LAT) begin
						lat[n*PW +: PW] <= pwdata[7:0];
					end else if (paddr[3:0] == O_MDIN) begin
						mdin[n*PW +: PW] <= pwdata[7:0];
					end else if (paddr[3:0] == O_MDOUT) begin
						mdout[n*PW +: PW] <= pwdata[7:0];
					end else if (paddr[3:0] == O_SKIP
						&& n != DIGONLY_PORT) begin
						skip[n*PW +: PW] <= pwdata[7:0];
					end
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_setup;
		psel && !penable && !pready && ce;
	endsequence
	property p_hiz_until_enable;
		(ce && !ctrl[B_XBAR_EN]) |=> (pad.oe == '0);
	endproperty
	a_hiz_until_enable: assert property (p_hiz_until_enable)
		else $error("pad driven before crossbar enable");
	property p_analog_off;
		ce |=> (((pad.oe | pad.pu) & ~$past(dig)) == '0);
	endproperty
	a_analog_off: assert property (p_analog_off)
		else $error("analog pin has driver or pull-up");
	property p_open_drain_low;
		ce |=> ((pad.oe & pad.o & ~$past(mdout)) == '0);
	endproperty
	a_open_drain_low: assert property (p_open_drain_low)
		else $error("open-drain pin driven high");
	property p_pullup_low;
		(pad.oe & ~pad.o & pad.pu) == '0;
	endproperty
	a_pullup_low: assert property (p_pullup_low)
		else $error("pull-up on while driving low");
	property p_pullup_off;
		(ce && ctrl[B_WPUD]) |=> (pad.pu == '0);
	endproperty
	a_pullup_off: assert property (p_pullup_off)
		else $error("pull-up on despite global disable");
	property p_skip_free;
		(owned & skip & ~({NPIN{1'b0}} | {{(NPIN-8){1'b0}}, 8'hf0})) == '0;
	endproperty
	a_skip_free: assert property (p_skip_free)
		else $error("reserved pin claimed by crossbar");
	property p_uart_fixed;
		sig_en[0] |-> (sig_pin[0] == 6'(PIN_UART)
			&& sig_pin[1] == 6'(PIN_UART + 1));
	endproperty
	a_uart_fixed: assert property (p_uart_fixed)
		else $error("serial port not on its fixed pins");
	property p_event;
		(ce && ev_hit) |=> ext_event;
	endproperty
	a_event: assert property (p_event)
		else $error("event not raised");
	property p_apb_answer;
		s_setup |=> (pready ##1 !pready);
	endproperty
	a_apb_answer: assert property (p_apb_answer)
		else $error("slave did not answer in access phase");
endmodule
